// ===== hdl/lsd_pkg.sv
// Package of constants and carrier types for the segment LCD controller
package lsd_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_FP = 41;
  localparam int NUM_BP = 4;
  localparam int SEG_WORDS = 21;
  localparam int SEG_AW = 5;
  localparam int FPEN_REGS = 6;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CLK_SRC = 8'h00;
  localparam logic [7:0] ADDR_SUPPLY = 8'h01;
  localparam logic [7:0] ADDR_LOW_POWER = 8'h02;
  localparam logic [7:0] ADDR_MAIN = 8'h03;
  localparam logic [7:0] ADDR_BLINK = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h05;
  localparam logic [7:0] ADDR_FPEN_BASE = 8'h08;
  localparam logic [7:0] ADDR_DATA_BASE = 8'h20;
  localparam logic [7:0] ADDR_MARK_BASE = 8'h40;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_REG = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CLK_SOURCE_BIT = 7;
  localparam int CLK_CLOCK_PRESCALE_BY_SIXTEEN_BIT = 6;
  localparam int CLK_ADJ_MSB = 5;
  localparam int SUP_PUMP_EN_BIT = 7;
  localparam int SUP_TRIPLER_BIT = 6;
  localparam int SUP_HIGH_DRIVE_BIT = 5;
  localparam int SUP_PUMP_CLK_MSB = 4;
  localparam int SUP_PUMP_CLK_LSB = 3;
  localparam int SUP_BYPASS_BIT = 2;
  localparam int SUP_SEL_MSB = 1;
  localparam int LP_OFF_WAIT_BIT = 1;
  localparam int LP_RUN_STOP_BIT = 0;
  localparam int MAIN_FRAME_CLOCK_SELECT_MSB = 5;
  localparam int MAIN_FRAME_CLOCK_SELECT_LSB = 3;
  localparam int MAIN_LOW_POWER_WAVEFORM_BIT = 2;
  localparam int MAIN_DUTY_MSB = 1;
  localparam int BLK_MODE_BIT = 3;
  localparam int BLK_RATE_MSB = 2;
  localparam int SEG_ODD_LSB = 4;

  // ---------------------------------------------------------------
  // Encodings and divider constants
  // ---------------------------------------------------------------
  localparam logic SRC_EXT_REF = 1'b0;
  localparam logic SRC_BUS = 1'b1;
  localparam logic [1:0] SUPPLY_EXTERNAL = 2'b10;
  localparam logic [1:0] DUTY_THIRD = 2'b10;
  localparam logic [1:0] DUTY_QUARTER = 2'b11;
  localparam logic [2:0] RATE_NONE = 3'b000;
  localparam logic [9:0] PRESCALE_BIG_SHIFT = 10'd4;
  localparam logic [13:0] BASE_DIV_UNIT = 14'h0040;
  localparam logic [11:0] BLINK_DIV_UNIT = 12'h010;
  localparam logic [SEG_AW-1:0] SEG_LAST = 5'h14;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic charge_pump_enable;
    logic pump_multiplier_select;
    logic high_drive_buffer;
    logic [1:0] pump_clock_adjust;
    logic buffer_bypass;
    logic external_supply;
    logic [1:0] supply_source_select;
  } lsd_supply_s;

  typedef struct packed {
    logic [1:0] duty;
    logic [2:0] frame_clock_select;
    logic [2:0] blink_rate;
    logic blink_mode;
  } lsd_frame_s;

  typedef enum logic [1:0] {RS_REG, RS_DATA, RS_MARK} lsd_rsrc_e;

endpackage

// ===== hdl/lsd_seg_mem.sv
// Segment word memory with one write port and two registered read ports
`timescale 1ns/1ps
module lsd_seg_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 21,
  parameter int AW = 5
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic [AW-1:0] a_addr_i,
  output logic [WIDTH-1:0] a_q_o,
  input wire logic [AW-1:0] b_addr_i,
  output logic [WIDTH-1:0] b_q_o
);
  logic [WIDTH-1:0] mem_reg [DEPTH];

  // ---------------------------------------------------------------
  // Storage, no reset so it maps onto plain RAM
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (wr_en_i && (int'(wr_addr_i) < DEPTH)) begin
      mem_reg[wr_addr_i] <= wr_data_i;
    end
  end

  // ---------------------------------------------------------------
  // Registered reads, out of range reads give zero
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_q_o <= '0;
      b_q_o <= '0;
    end else begin
      a_q_o <= (int'(a_addr_i) < DEPTH) ? mem_reg[a_addr_i] : '0;
      b_q_o <= (int'(b_addr_i) < DEPTH) ? mem_reg[b_addr_i] : '0;
    end
  end
endmodule

// ===== hdl/lsd_lcd_ctrl.sv
// Segment LCD controller: registers, clock chain, frame phasing, blink, segment scan
`timescale 1ns/1ps
module lsd_lcd_ctrl (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic lcd_ref_clk_i,
  output lsd_pkg::lsd_supply_s supply_o,
  output logic clk_from_bus_o,
  output logic off_in_wait_o,
  output logic run_in_deep_stop_o,
  output logic low_power_waveform_o,
  output logic [3:0] bp_active_o,
  output logic [40:0] fp_enable_o,
  output logic [40:0] fp_seg_o,
  output logic blink_off_o,
  output logic frame_start_o
);
  import lsd_pkg::*;

  // ---------------------------------------------------------------
  // Decode helper
  // ---------------------------------------------------------------
  function automatic logic in_range(input logic [7:0] a, input logic [7:0] base,
                                    input int count);
    logic [7:0] off;
    off = a - base;
    in_range = (a >= base) && (int'(off) < count);
  endfunction

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [7:0] clk_src_reg;
  logic [7:0] supply_reg;
  logic [7:0] low_power_reg;
  logic [7:0] main_reg;
  logic [7:0] blink_reg;
  logic [7:0] fpen_reg [FPEN_REGS];
  logic [47:0] fpen_flat;
  logic [7:0] seg_off;
  logic [7:0] mark_off;
  logic data_hit;
  logic mark_hit;
  logic [SEG_AW-1:0] wr_word;
  logic [SEG_AW-1:0] rd_word;
  logic [7:0] data_a_q;
  logic [7:0] data_b_q;
  logic [7:0] mark_a_q;
  logic [7:0] mark_b_q;
  logic rd_pend_reg;
  lsd_rsrc_e rd_src_reg;
  logic [7:0] reg_q_reg;
  logic [7:0] reg_q_next;
  lsd_frame_s frame_reg;
  logic ref_q_reg;
  logic src_tick;
  logic [9:0] pre_cnt_reg;
  logic [9:0] pre_lim;
  logic pre_tick;
  logic [13:0] base_cnt_reg;
  logic [13:0] base_lim;
  logic base_tick;
  logic [1:0] phase_reg;
  logic [1:0] phase_next;
  logic frame_end;
  logic [11:0] blink_cnt_reg;
  logic [11:0] blink_lim;
  logic blink_off_reg;
  logic scan_busy_reg;
  logic [SEG_AW-1:0] scan_idx_reg;
  logic [1:0] scan_phase_reg;
  logic rv_reg;
  logic [SEG_AW-1:0] rv_idx_reg;
  logic [41:0] build_reg;
  logic lo_on;
  logic hi_on;

  // ---------------------------------------------------------------
  // Address decode for the segment memories
  // ---------------------------------------------------------------
  assign data_hit = in_range(addr_i, ADDR_DATA_BASE, SEG_WORDS);
  assign mark_hit = in_range(addr_i, ADDR_MARK_BASE, SEG_WORDS);
  assign seg_off = addr_i - ADDR_DATA_BASE;
  assign mark_off = addr_i - ADDR_MARK_BASE;
  assign wr_word = data_hit ? seg_off[SEG_AW-1:0] : mark_off[SEG_AW-1:0];
  assign rd_word = wr_word;

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_src_reg <= RST_REG;
      supply_reg <= RST_REG;
      low_power_reg <= RST_REG;
      main_reg <= RST_REG;
      blink_reg <= RST_REG;
    end else if (wr_i) begin
      if (addr_i == ADDR_CLK_SRC) begin
        clk_src_reg <= wdata_i;
      end else if (addr_i == ADDR_SUPPLY) begin
        supply_reg <= wdata_i;
      end else if (addr_i == ADDR_LOW_POWER) begin
        low_power_reg <= wdata_i;
      end else if (addr_i == ADDR_MAIN) begin
        main_reg <= wdata_i;
      end else if (addr_i == ADDR_BLINK) begin
        blink_reg <= wdata_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // Frontplane enables, one bit per pin
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < FPEN_REGS; g++) begin : gen_fpen
      always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          fpen_reg[g] <= RST_REG;
        end else if (wr_i && (addr_i == ADDR_FPEN_BASE + 8'(g))) begin
          fpen_reg[g] <= wdata_i;
        end
      end
      assign fpen_flat[g*8 +: 8] = fpen_reg[g];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Segment data and per segment blink marks
  // ---------------------------------------------------------------
  lsd_seg_mem #(.WIDTH(8), .DEPTH(SEG_WORDS), .AW(SEG_AW)) u_data_mem (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .wr_en_i(wr_i && data_hit),
    .wr_addr_i(wr_word),
    .wr_data_i(wdata_i),
    .a_addr_i(rd_word),
    .a_q_o(data_a_q),
    .b_addr_i(scan_idx_reg),
    .b_q_o(data_b_q)
  );

  lsd_seg_mem #(.WIDTH(8), .DEPTH(SEG_WORDS), .AW(SEG_AW)) u_mark_mem (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .wr_en_i(wr_i && mark_hit),
    .wr_addr_i(wr_word),
    .wr_data_i(wdata_i),
    .a_addr_i(rd_word),
    .a_q_o(mark_a_q),
    .b_addr_i(scan_idx_reg),
    .b_q_o(mark_b_q)
  );

  // ---------------------------------------------------------------
  // Register read path, data valid only the cycle after the strobe
  // ---------------------------------------------------------------
  always_comb begin
    reg_q_next = 8'h00;
    if (addr_i == ADDR_CLK_SRC) begin
      reg_q_next = clk_src_reg;
    end else if (addr_i == ADDR_SUPPLY) begin
      reg_q_next = supply_reg;
    end else if (addr_i == ADDR_LOW_POWER) begin
      reg_q_next = low_power_reg;
    end else if (addr_i == ADDR_MAIN) begin
      reg_q_next = main_reg;
    end else if (addr_i == ADDR_BLINK) begin
      reg_q_next = blink_reg;
    end else if (addr_i == ADDR_STATUS) begin
      reg_q_next = {blink_off_reg, scan_busy_reg, 2'h0, frame_reg.duty, phase_reg};
    end else if (in_range(addr_i, ADDR_FPEN_BASE, FPEN_REGS)) begin
      reg_q_next = fpen_reg[addr_i[2:0]];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_pend_reg <= 1'b0;
      rd_src_reg <= RS_REG;
      reg_q_reg <= 8'h00;
    end else begin
      rd_pend_reg <= rd_i;
      reg_q_reg <= reg_q_next;
      if (data_hit) begin
        rd_src_reg <= RS_DATA;
      end else if (mark_hit) begin
        rd_src_reg <= RS_MARK;
      end else begin
        rd_src_reg <= RS_REG;
      end
    end
  end

  always_comb begin
    rdata_o = 8'h00;
    if (rd_pend_reg) begin
      case (rd_src_reg)
        RS_DATA: rdata_o = data_a_q;
        RS_MARK: rdata_o = mark_a_q;
        default: rdata_o = reg_q_reg;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Clock source and prescaler
  // ---------------------------------------------------------------
  // Reference is slow against the core clock, so a rising edge is one tick
  assign src_tick = (clk_src_reg[CLK_SOURCE_BIT] == SRC_BUS) ? 1'b1 :
                    (lcd_ref_clk_i && !ref_q_reg);
  assign pre_lim = (({4'h0, clk_src_reg[CLK_ADJ_MSB:0]} + 10'd1)
                   << (clk_src_reg[CLK_CLOCK_PRESCALE_BY_SIXTEEN_BIT] ? PRESCALE_BIG_SHIFT : 10'd0))
                   - 10'd1;
  assign pre_tick = src_tick && (pre_cnt_reg >= pre_lim);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_q_reg <= 1'b0;
      pre_cnt_reg <= 10'h000;
    end else begin
      ref_q_reg <= lcd_ref_clk_i;
      if (pre_tick) begin
        pre_cnt_reg <= 10'h000;
      end else if (src_tick) begin
        pre_cnt_reg <= pre_cnt_reg + 10'd1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Base frequency divider, set by the frame clock select
  // ---------------------------------------------------------------
  assign base_lim = (BASE_DIV_UNIT << frame_reg.frame_clock_select) - 14'd1;
  assign base_tick = pre_tick && (base_cnt_reg >= base_lim);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      base_cnt_reg <= 14'h0000;
    end else if (base_tick) begin
      base_cnt_reg <= 14'h0000;
    end else if (pre_tick) begin
      base_cnt_reg <= base_cnt_reg + 14'd1;
    end
  end

  // ---------------------------------------------------------------
  // Backplane phasing; settings latched only at frame end
  // ---------------------------------------------------------------
  // Duty code plus one is the backplane count
  assign frame_end = base_tick && (phase_reg >= frame_reg.duty);
  assign phase_next = frame_end ? 2'h0 : phase_reg + 2'd1;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_reg <= 2'h0;
      bp_active_o <= 4'h1;
      frame_start_o <= 1'b0;
      frame_reg <= '0;
    end else begin
      frame_start_o <= frame_end;
      if (base_tick) begin
        phase_reg <= phase_next;
        bp_active_o <= 4'h1 << phase_next;
      end
      if (frame_end) begin
        // Mid frame changes would tear the waveform, so wait for the edge
        frame_reg.duty <= main_reg[MAIN_DUTY_MSB:0];
        frame_reg.frame_clock_select <= main_reg[MAIN_FRAME_CLOCK_SELECT_MSB:MAIN_FRAME_CLOCK_SELECT_LSB];
        frame_reg.blink_rate <= blink_reg[BLK_RATE_MSB:0];
        frame_reg.blink_mode <= blink_reg[BLK_MODE_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Blink timer, counts base ticks
  // ---------------------------------------------------------------
  assign blink_lim = (BLINK_DIV_UNIT << frame_reg.blink_rate) - 12'd1;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blink_cnt_reg <= 12'h000;
      blink_off_reg <= 1'b0;
    end else if (frame_reg.blink_rate == RATE_NONE) begin
      blink_cnt_reg <= 12'h000;
      blink_off_reg <= 1'b0;
    end else if (base_tick) begin
      if (blink_cnt_reg >= blink_lim) begin
        blink_cnt_reg <= 12'h000;
        blink_off_reg <= !blink_off_reg;
      end else begin
        blink_cnt_reg <= blink_cnt_reg + 12'd1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Segment scan: walks the words once per backplane phase
  // ---------------------------------------------------------------
  // A scan takes 22 core cycles, far below any base period
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scan_busy_reg <= 1'b0;
      scan_idx_reg <= '0;
      scan_phase_reg <= 2'h0;
      rv_reg <= 1'b0;
      rv_idx_reg <= '0;
    end else begin
      rv_reg <= scan_busy_reg;
      rv_idx_reg <= scan_idx_reg;
      if (base_tick) begin
        scan_busy_reg <= 1'b1;
        scan_idx_reg <= '0;
        scan_phase_reg <= phase_next;
      end else if (scan_busy_reg) begin
        if (scan_idx_reg == SEG_LAST) begin
          scan_busy_reg <= 1'b0;
        end else begin
          scan_idx_reg <= scan_idx_reg + 5'd1;
        end
      end
    end
  end

  // Low nibble serves the even frontplane, high nibble the odd one
  always_comb begin
    lo_on = data_b_q[scan_phase_reg] &&
            !(blink_off_reg && (frame_reg.blink_mode || mark_b_q[scan_phase_reg]));
    hi_on = data_b_q[SEG_ODD_LSB + int'(scan_phase_reg)] &&
            !(blink_off_reg && (frame_reg.blink_mode ||
              mark_b_q[SEG_ODD_LSB + int'(scan_phase_reg)]));
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      build_reg <= '0;
      fp_seg_o <= '0;
    end else if (rv_reg) begin
      build_reg[{rv_idx_reg, 1'b0}] <= lo_on;
      build_reg[{rv_idx_reg, 1'b1}] <= hi_on;
      if (rv_idx_reg == SEG_LAST) begin
        fp_seg_o <= {lo_on, build_reg[39:0]} & fpen_flat[40:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Supply and mode outputs to the analog side
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      supply_o <= '0;
      clk_from_bus_o <= 1'b0;
      off_in_wait_o <= 1'b0;
      run_in_deep_stop_o <= 1'b0;
      low_power_waveform_o <= 1'b0;
      fp_enable_o <= '0;
      blink_off_o <= 1'b0;
    end else begin
      supply_o.charge_pump_enable <= supply_reg[SUP_PUMP_EN_BIT];
      supply_o.pump_multiplier_select <= supply_reg[SUP_TRIPLER_BIT];
      supply_o.high_drive_buffer <= supply_reg[SUP_HIGH_DRIVE_BIT];
      supply_o.pump_clock_adjust <= supply_reg[SUP_PUMP_CLK_MSB:SUP_PUMP_CLK_LSB];
      supply_o.buffer_bypass <= supply_reg[SUP_BYPASS_BIT];
      supply_o.external_supply <= (supply_reg[SUP_SEL_MSB:0] == SUPPLY_EXTERNAL);
      supply_o.supply_source_select <= supply_reg[SUP_SEL_MSB:0];
      clk_from_bus_o <= clk_src_reg[CLK_SOURCE_BIT];
      off_in_wait_o <= low_power_reg[LP_OFF_WAIT_BIT];
      run_in_deep_stop_o <= low_power_reg[LP_RUN_STOP_BIT];
      low_power_waveform_o <= main_reg[MAIN_LOW_POWER_WAVEFORM_BIT];
      fp_enable_o <= fpen_flat[40:0];
      blink_off_o <= blink_off_reg;
    end
  end
endmodule

// ===== verification/lsd_lcd_ctrl_sva.sv
// Checker of port relations for the segment LCD controller
`timescale 1ns/1ps
module lsd_lcd_ctrl_sva
  import lsd_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire lsd_pkg::lsd_supply_s supply_o,
  input wire logic clk_from_bus_o,
  input wire logic [3:0] bp_active_o,
  input wire logic [40:0] fp_enable_o,
  input wire logic [40:0] fp_seg_o,
  input wire logic frame_start_o
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  property p_rd_idle; !rd_i |=> rdata_o == 8'h00; endproperty
  a_rd_idle:
    assert property (p_rd_idle) else $error("read data outside read slot");
  property p_src; wr_i && addr_i == ADDR_CLK_SRC |-> ##2
    clk_from_bus_o == $past(wdata_i[CLK_SOURCE_BIT], 2); endproperty
  a_src:
    assert property (p_src) else $error("clock source output wrong");
  property p_pump; wr_i && addr_i == ADDR_SUPPLY |-> ##2
    supply_o.charge_pump_enable == $past(wdata_i[SUP_PUMP_EN_BIT], 2); endproperty
  a_pump:
    assert property (p_pump) else $error("pump enable output wrong");
  property p_mult; wr_i && addr_i == ADDR_SUPPLY |-> ##2
    supply_o.pump_multiplier_select == $past(wdata_i[SUP_TRIPLER_BIT], 2); endproperty
  a_mult:
    assert property (p_mult) else $error("multiplier output wrong");
  property p_byp; wr_i && addr_i == ADDR_SUPPLY |-> ##2
    supply_o.buffer_bypass == $past(wdata_i[SUP_BYPASS_BIT], 2); endproperty
  a_byp:
    assert property (p_byp) else $error("bypass output wrong");
  property p_ext;
    supply_o.external_supply == (supply_o.supply_source_select == SUPPLY_EXTERNAL); endproperty
  a_ext:
    assert property (p_ext) else $error("external supply flag wrong");
  property p_fp; !$stable(fp_seg_o) |-> (fp_seg_o & ~fp_enable_o) == 41'h0; endproperty
  a_fp:
    assert property (p_fp) else $error("disabled frontplane drives");
  property p_bp; $onehot(bp_active_o); endproperty
  a_bp:
    assert property (p_bp) else $error("backplane phase not one-hot");
  property p_frame; frame_start_o |=> !frame_start_o [*8]; endproperty
  a_frame:
    assert property (p_frame) else $error("frame pulse too long");
endmodule

bind lsd_lcd_ctrl lsd_lcd_ctrl_sva lsd_lcd_ctrl_sva_inst (.clock_i(clock_i),
  .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .supply_o(supply_o), .clk_from_bus_o(clk_from_bus_o),
  .bp_active_o(bp_active_o), .fp_enable_o(fp_enable_o), .fp_seg_o(fp_seg_o),
  .frame_start_o(frame_start_o));

// ===== verification/lsd_glass_model.sv
// Passive multiplexed glass that records the lit segment map per backplane
`timescale 1ns/1ps
module lsd_glass_model (
  input wire logic clock_i,
  input wire logic [3:0] bp_active_i,
  input wire logic [40:0] fp_seg_i,
  input wire logic [40:0] fp_enable_i,
  output logic [3:0][40:0] lit_o
);
  logic [3:0] bp_q;
  logic [40:0] seg_q;
  // Commit at phase end only, the scan lags the backplane step
  always @(posedge clock_i) begin
    bp_q <= bp_active_i;
    seg_q <= fp_seg_i & fp_enable_i;
    for (int b = 0; b < 4; b++) begin
      if (bp_q[b] && bp_active_i != bp_q) begin
        lit_o[b] <= seg_q;
      end
    end
  end
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the segment LCD controller
`timescale 1ns/1ps
module tb_top;
  import lsd_pkg::*;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic lcd_ref_clk_i = 1'b0;
  logic [1:0] rc = 2'h0;
  logic [7:0] rdata_o;
  lsd_supply_s supply_o;
  logic clk_from_bus_o, off_in_wait_o, run_in_deep_stop_o, low_power_waveform_o;
  logic [3:0] bp_active_o;
  logic [40:0] fp_enable_o, fp_seg_o;
  logic blink_off_o, frame_start_o;
  logic [3:0][40:0] lit;
  int n_mismatch = 0;
  int num_checks = 0;
  int mdl [0:255] = '{default: 0};
  logic [7:0] rnd = 8'h52;
  // ----
  // Clocks and instances
  // ----
  always #2 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    rc <= rc + 2'h1;
    lcd_ref_clk_i <= rc[1];
  end
  lsd_lcd_ctrl lsd_lcd_ctrl_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .lcd_ref_clk_i(lcd_ref_clk_i), .supply_o(supply_o), .clk_from_bus_o(clk_from_bus_o),
    .off_in_wait_o(off_in_wait_o), .run_in_deep_stop_o(run_in_deep_stop_o),
    .low_power_waveform_o(low_power_waveform_o), .bp_active_o(bp_active_o),
    .fp_enable_o(fp_enable_o), .fp_seg_o(fp_seg_o), .blink_off_o(blink_off_o),
    .frame_start_o(frame_start_o));
  lsd_glass_model lsd_glass_model_inst (.clock_i(clock_i), .bp_active_i(bp_active_o),
    .fp_seg_i(fp_seg_o), .fp_enable_i(fp_enable_o), .lit_o(lit));
  // ----
  // Model and bus tasks
  // ----
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Mapped registers keep all eight bits; holes read back as zero
  function automatic int msk(input int a);
    if (a < 5 || (a > 7 && a < 14) || (a > 31 && a < 53) || (a > 63 && a < 85)) return 255;
    return 0;
  endfunction
  function automatic logic [40:0] exp_lit(input int b);
    logic [40:0] e;
    for (int f = 0; f < 41; f++) e[f] = mdl[32 + f / 2][(f % 2) * 4 + b] & mdl[8 + f / 8][f % 8];
    return e;
  endfunction
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    mdl[a] = d & msk(a);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, mdl[a] & msk(a));
  endtask
  task automatic outs();
    logic [7:0] s;
    s = 8'(mdl[1]);
    @(posedge clock_i) #1 chk({supply_o, clk_from_bus_o, off_in_wait_o, run_in_deep_stop_o,
      low_power_waveform_o, fp_enable_o}, {s[7:2], s[1:0] == 2'b10, s[1:0], mdl[0][7],
      mdl[2][1], mdl[2][0], mdl[3][2], mdl[13][0], 8'(mdl[12]), 8'(mdl[11]), 8'(mdl[10]),
      8'(mdl[9]), 8'(mdl[8])});
  endtask
  task automatic frm(output int n, output logic [3:0] s);
    int w;
    w = 0;
    n = 0;
    s = 4'h0;
    while (frame_start_o !== 1'b1 && w < 20000) @(posedge clock_i) #1 w++;
    do begin
      @(posedge clock_i) #1 n++;
      s |= bp_active_o;
    end while (frame_start_o !== 1'b1 && n < 20000);
  endtask
  // Off half is judged only once settled, the scan lags blink by one 22-cycle scan
  task automatic blk(output int n, output logic [40:0] o);
    int w;
    w = 0;
    n = 0;
    o = '0;
    while (blink_off_o !== 1'b0 && w < 9000) @(posedge clock_i) #1 w++;
    while (blink_off_o !== 1'b1 && w < 9000) @(posedge clock_i) #1 w++;
    while (blink_off_o === 1'b1 && n < 9000) begin
      if (n > 200) o |= fp_seg_o;
      @(posedge clock_i) #1 n++;
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----
  // Tests
  // ----
  initial begin
    int n;
    logic [3:0] s;
    logic [40:0] o;
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 14; a++) if (a != 5) rd(8'(a));
    wr(8'h06, 8'hFF);
    rd(8'h06);
    rd(8'hA0);
    $display("test reset done");
    // Slow clock settings kept out, a late frame end would stall later tests
    for (int a = 0; a < 85; a++) begin
      if (msk(a) != 0) begin
        rnd = lfsr(rnd);
        wr(8'(a), rnd & (a == 0 ? 8'h80 : a == 3 ? 8'h0F : 8'hFF));
        rd(8'(a));
      end
    end
    outs();
    $display("test registers done");
    wr(ADDR_CLK_SRC, 8'h80);
    wr(ADDR_MAIN, 8'h02);
    wr(ADDR_BLINK, 8'h00);
    for (int k = 0; k < 21; k++) begin
      wr(8'(32 + k), k == 0 ? 8'hAA : k == 1 ? 8'h03 : 8'h00);
      wr(8'(64 + k), k == 0 ? 8'h02 : 8'h00);
    end
    for (int p = 0; p < 2; p++) begin
      for (int k = 8; k < 14; k++) wr(8'(k), (p == 1 && k == 8) ? 8'hFB : 8'hFF);
      repeat (3) frm(n, s);
      chk(n, 192);
      chk(s, 4'h7);
      for (int b = 0; b < 3; b++) chk(lit[b], exp_lit(b));
    end
    $display("test third duty done");
    wr(ADDR_BLINK, 8'h09);
    blk(n, o);
    chk(n, 2048);
    chk(o, 41'h0);
    wr(ADDR_BLINK, 8'h01);
    blk(n, o);
    chk(o[1:0], 2'b10);
    wr(ADDR_BLINK, 8'h00);
    $display("test blink done");
    wr(ADDR_MAIN, 8'h1B);
    repeat (3) frm(n, s);
    chk(n, 2048);
    chk(s, 4'hF);
    chk(lit[3], exp_lit(3));
    $display("test quarter duty done");
    wr(ADDR_CLK_SRC, 8'h00);
    wr(ADDR_MAIN, 8'h12);
    repeat (3) frm(n, s);
    chk(n, 3072);
    $display("test reference clock done");
    conclude();
  end
  initial begin
    #400000;
    n_mismatch++;
    conclude();
  end
endmodule
